// ==== verilog/t16_timer.sv ====
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module t16_timer #(
   parameter int DIV1 = t16_pkg::DIV_SEL1,
   parameter int DIV2 = t16_pkg::DIV_SEL2
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RESET,
   input  wire logic [2:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   input  wire logic        TIMER_INPUT_0,
   input  wire logic        TIMER_INPUT_1,
   output logic             TIMER_OUTPUT_PIN,
   output logic             MATCH0_IRQ,
   output logic             MATCH1_IRQ
);

   logic [7:0]         mode_control_reg;
   logic [7:0]         capture_compare_control_reg;
   logic [7:0]         output_control_reg;
   t16_pkg::t16_presc_s prescale_mode_reg;
   logic [15:0]        compare_capture_reg0;
   logic [15:0]        compare_capture_reg1;
   logic [15:0]        main_counter;
   logic               overflow_flag;
   logic               out_ff;
   logic               run_q;
   logic [7:0]         div_cnt;
   logic [1:0]         prev_smp;
   logic [1:0]         lvl;
   logic [1:0]         rise;
   logic [1:0]         fall;

   // edge field decode; the prohibited code detects nothing
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic r,
                                     input logic f);
      edge_hit = 1'b0;
      case (sel)
         t16_pkg::T16_FALL: edge_hit = f;
         t16_pkg::T16_RISE: edge_hit = r;
         t16_pkg::T16_BOTH: edge_hit = r | f;
         default:           edge_hit = 1'b0;
      endcase
   endfunction

   // bus decode
   wire wr_mode  = WR && (ADDR == t16_pkg::A_MODE);
   wire wr_ccc   = WR && (ADDR == t16_pkg::A_CCC);
   wire wr_outc  = WR && (ADDR == t16_pkg::A_OUTC);
   wire wr_presc = WR && (ADDR == t16_pkg::A_PRESC);
   wire wr_cr0   = WR && (ADDR == t16_pkg::A_CR0);
   wire wr_cr1   = WR && (ADDR == t16_pkg::A_CR1);
   wire wr_stat  = WR && (ADDR == t16_pkg::A_STAT);

   wire [1:0] mode_bits = mode_control_reg[t16_pkg::MODE_LSB +: 2];
   t16_pkg::t16_mode_e mode;
   assign mode = t16_pkg::t16_mode_e'(mode_bits);

   wire running  = (mode != t16_pkg::T16_STOP);
   wire starting = running && !run_q;

   wire cr0_cap = capture_compare_control_reg[t16_pkg::CCC_CR0_CAP];
   wire cr0_src = capture_compare_control_reg[t16_pkg::CCC_CR0_SRC];
   wire cr1_cap = capture_compare_control_reg[t16_pkg::CCC_CR1_CAP];
   wire oe      = output_control_reg[t16_pkg::OUTC_OE];
   wire inv0    = output_control_reg[t16_pkg::OUTC_INV0];
   wire inv1    = output_control_reg[t16_pkg::OUTC_INV1];

   wire [1:0] clk_sel = prescale_mode_reg.clk_sel;
   wire [1:0] es0     = prescale_mode_reg.in0_edge;
   wire [1:0] es1     = prescale_mode_reg.in1_edge;

   // prescaler: one-cycle enable pulses, no derived clocks
   localparam logic [7:0] D1_LAST = 8'(DIV1 - 1);
   localparam logic [7:0] D2_LAST = 8'(DIV2 - 1);
   wire div1_hit = ((div_cnt & D1_LAST) == D1_LAST);
   wire div2_hit = ((div_cnt & D2_LAST) == D2_LAST);
   wire ext_clk  = (clk_sel == 2'b11);

   // external-clock mode samples every cycle, so input 0 can be the count clock
   wire smp_en = ext_clk ? 1'b1 :
                 (clk_sel == 2'b01) ? div1_hit :
                 (clk_sel == 2'b10) ? div2_hit : 1'b1;

   wire v0_raw = edge_hit(es0, rise[0], fall[0]);
   wire v0_inv = edge_hit((es0 == t16_pkg::T16_RISE) ? 2'b00 :
                          (es0 == t16_pkg::T16_FALL) ? 2'b01 : 2'b10,
                          rise[0], fall[0]);
   wire v1_raw = edge_hit(es1, rise[1], fall[1]);

   wire tick = ext_clk ? v0_raw : smp_en;

   // input filters: a level counts only after two equal samples
   wire [1:0] pins = {TIMER_INPUT_1, TIMER_INPUT_0};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_flt
         wire settle = smp_en && (prev_smp[gi] == pins[gi])
                       && (pins[gi] != lvl[gi]);
         always_ff @(posedge SYS_CLK) begin
            if (RESET) begin
               prev_smp[gi] <= 1'b0;
               lvl[gi]      <= 1'b0;
               rise[gi]     <= 1'b0;
               fall[gi]     <= 1'b0;
            end else begin
               if (smp_en) begin
                  prev_smp[gi] <= pins[gi];
               end
               if (settle) begin
                  lvl[gi] <= pins[gi];
               end
               rise[gi] <= settle && pins[gi];
               fall[gi] <= settle && !pins[gi];
            end
         end
      end
   endgenerate

   // compare matches only while that register's capture bit (CCC_CR0_CAP or CCC_CR1_CAP) is clear
   wire m0 = tick && running && !cr0_cap
             && (main_counter == compare_capture_reg0);
   wire m1 = tick && running && !cr1_cap
             && (main_counter == compare_capture_reg1);
   wire clr_match = m0 && (mode == t16_pkg::T16_CLRM);

   // captures
   wire cap1    = running && v0_raw && (cr1_cap || mode == t16_pkg::T16_RESTART);
   wire cap0_i1 = running && cr0_cap && !cr0_src && v1_raw;
   wire cap0_i0 = running && cr0_cap && cr0_src && v0_inv;
   wire cap0    = cap0_i1 || cap0_i0;
   wire restart = running && v0_raw && (mode == t16_pkg::T16_RESTART);

   // counter reaches the top in free and restart modes, and in clear mode only when reg0 allows it
   wire ovf_set = tick && running && !restart
                  && (main_counter == t16_pkg::CNT_MAX);

   logic [15:0] next_cnt;
   always_comb begin
      next_cnt = main_counter;
      if (!running) begin
         next_cnt = t16_pkg::RST_WORD;
      end else if (restart) begin
         next_cnt = t16_pkg::RST_WORD;
      end else if (clr_match) begin
         next_cnt = t16_pkg::RST_WORD;
      end else if (tick) begin
         next_cnt = 16'(main_counter + 16'h0001);
      end
   end

   wire next_irq0 = m0 || cap0_i1;
   wire next_irq1 = m1 || cap1;

   // flop starts high so the first phase lasts reg1 clocks
   wire tgl0 = m0 && inv0;
   wire tgl1 = m1 && inv1;
   wire next_ff = !running ? 1'b0 :
                  starting ? 1'b1 :
                  (out_ff ^ tgl0 ^ tgl1);

   // set wins over a software clear
   wire ovf_clr  = wr_stat && !WDATA[t16_pkg::STAT_OVF];
   wire next_ovf = ovf_set || (overflow_flag && !ovf_clr);

   localparam logic [7:0] RST_BYTE_V = t16_pkg::RST_BYTE;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         div_cnt <= RST_BYTE_V;
         run_q   <= 1'b0;
      end else begin
         div_cnt <= 8'(div_cnt + 8'h01);
         run_q   <= running;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         main_counter  <= t16_pkg::RST_WORD;
         overflow_flag <= 1'b0;
         out_ff        <= 1'b0;
         MATCH0_IRQ    <= 1'b0;
         MATCH1_IRQ    <= 1'b0;
      end else begin
         main_counter  <= next_cnt;
         overflow_flag <= next_ovf;
         out_ff        <= next_ff;
         MATCH0_IRQ    <= next_irq0;
         MATCH1_IRQ    <= next_irq1;
      end
   end

   // captures beat a software write in the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         compare_capture_reg0 <= t16_pkg::RST_WORD;
         compare_capture_reg1 <= t16_pkg::RST_WORD;
      end else begin
         if (cap0) begin
            compare_capture_reg0 <= main_counter;
         end else if (wr_cr0) begin
            compare_capture_reg0 <= WDATA;
         end
         if (cap1) begin
            compare_capture_reg1 <= main_counter;
         end else if (wr_cr1) begin
            compare_capture_reg1 <= WDATA;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         mode_control_reg            <= RST_BYTE_V;
         capture_compare_control_reg <= RST_BYTE_V;
         output_control_reg          <= RST_BYTE_V;
         prescale_mode_reg           <= t16_pkg::t16_presc_s'(RST_BYTE_V);
      end else begin
         if (wr_mode) begin
            mode_control_reg <= WDATA[7:0];
         end
         if (wr_ccc) begin
            capture_compare_control_reg <= WDATA[7:0];
         end
         if (wr_outc) begin
            output_control_reg <= WDATA[7:0];
         end
         if (wr_presc) begin
            prescale_mode_reg <= t16_pkg::t16_presc_s'({WDATA[7:4], 2'b00, WDATA[1:0]});
         end
      end
   end

   // read mux
   wire [15:0] rd_mux =
      (ADDR == t16_pkg::A_MODE)  ? {8'h00, mode_control_reg} :
      (ADDR == t16_pkg::A_CCC)   ? {8'h00, capture_compare_control_reg} :
      (ADDR == t16_pkg::A_OUTC)  ? {8'h00, output_control_reg} :
      (ADDR == t16_pkg::A_PRESC) ? {8'h00, prescale_mode_reg} :
      (ADDR == t16_pkg::A_CR0)   ? compare_capture_reg0 :
      (ADDR == t16_pkg::A_CR1)   ? compare_capture_reg1 :
      (ADDR == t16_pkg::A_CNT)   ? main_counter :
                                   {15'h0000, overflow_flag};

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         RDATA <= t16_pkg::RST_WORD;
      end else if (RD) begin
         RDATA <= rd_mux;
      end else begin
         RDATA <= t16_pkg::RST_WORD;
      end
   end

   assign TIMER_OUTPUT_PIN = oe && out_ff;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   sequence s_cap1_done;
      (compare_capture_reg1 == $past(main_counter)) ##0 MATCH1_IRQ;
   endsequence

   sequence s_cap0_done;
      (compare_capture_reg0 == $past(main_counter)) ##0 MATCH0_IRQ;
   endsequence

   property p_interval_clear;
      clr_match && !restart |=> (main_counter == 16'h0000) && MATCH0_IRQ;
   endproperty
   a_interval_clear: assert property (p_interval_clear)
      else $error("match0 did not clear counter with request");

   property p_count_step;
      tick && running && !clr_match && !restart
         |=> main_counter == 16'($past(main_counter) + 16'h0001);
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("counter did not step by one");

   property p_ovf_top;
      !$past(overflow_flag) && overflow_flag |-> $past(main_counter) == t16_pkg::CNT_MAX;
   endproperty
   a_ovf_top: assert property (p_ovf_top)
      else $error("overflow set away from counter top");

   property p_fast_clock;
      clk_sel == 2'b00 |-> tick;
   endproperty
   a_fast_clock: assert property (p_fast_clock)
      else $error("undivided count clock missed a tick");

   property p_filter;
      rise[0] |-> lvl[0] && !$past(lvl[0]) && $past(prev_smp[0]);
   endproperty
   a_filter: assert property (p_filter)
      else $error("edge reported without two samples");

   property p_cap1;
      cap1 |=> s_cap1_done;
   endproperty
   a_cap1: assert property (p_cap1)
      else $error("input 0 capture into reg1 wrong");

   property p_cap0;
      cap0_i1 |=> s_cap0_done;
   endproperty
   a_cap0: assert property (p_cap0)
      else $error("input 1 capture into reg0 wrong");

   property p_restart;
      restart |=> main_counter == 16'h0000;
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart did not clear counter");

   property p_inv1;
      running && !starting && tgl1 && !tgl0 |=> out_ff != $past(out_ff);
   endproperty
   a_inv1: assert property (p_inv1)
      else $error("flop did not invert on match1");

   property p_inv0;
      running && !starting && tgl0 && !tgl1 |=> out_ff != $past(out_ff);
   endproperty
   a_inv0: assert property (p_inv0)
      else $error("flop did not invert on match0");

   property p_pin_off;
      !oe |-> !TIMER_OUTPUT_PIN;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("output pin high while disabled");

endmodule

// ==== verilog/t16_pkg.sv ====
package t16_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   localparam logic [2:0] A_MODE  = 3'h0;
   localparam logic [2:0] A_CCC   = 3'h1;
   localparam logic [2:0] A_OUTC  = 3'h2;
   localparam logic [2:0] A_PRESC = 3'h3;
   localparam logic [2:0] A_CR0   = 3'h4;
   localparam logic [2:0] A_CR1   = 3'h5;
   localparam logic [2:0] A_CNT   = 3'h6;
   localparam logic [2:0] A_STAT  = 3'h7;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] CNT_MAX  = 16'hFFFF;
   localparam int MODE_LSB    = 2;
   localparam int CCC_CR0_CAP = 0;
   localparam int CCC_CR0_SRC = 1;
   localparam int CCC_CR1_CAP = 2;
   localparam int OUTC_OE     = 0;
   localparam int OUTC_INV0   = 1;
   localparam int OUTC_INV1   = 4;
   localparam int STAT_OVF    = 0;
   localparam int DIV_SEL1    = 4;
   localparam int DIV_SEL2    = 256;
   typedef enum logic [1:0] {
      T16_STOP    = 2'b00,
      T16_RESTART = 2'b01,
      T16_FREE    = 2'b10,
      T16_CLRM    = 2'b11
   } t16_mode_e;
   typedef enum logic [1:0] {
      T16_FALL = 2'b00,
      T16_RISE = 2'b01,
      T16_PROH = 2'b10,
      T16_BOTH = 2'b11
   } t16_edge_e;
   typedef struct packed {
      logic [1:0] in1_edge;
      logic [1:0] in0_edge;
      logic [1:0] rsv;
      logic [1:0] clk_sel;
   } t16_presc_s;
endpackage

// ==== verification/t16_pulse_src.sv ====
`timescale 1ns/100ps
module t16_pulse_src (
   input  wire logic sys_clk,
   output logic      pin0,
   output logic      pin1
);
   initial begin
      pin0 = 1'b0;
      pin1 = 1'b0;
   end
   // levels change only just after a clock edge, like a synchronised source
   task automatic set_pin(input int p, input logic v);
      @(posedge sys_clk);
      if (p == 0)
         pin0 <= v;
      else
         pin1 <= v;
   endtask
   // one cycle high: shorter than two samples, must leave no trace
   task automatic glitch(input int p);
      set_pin(p, 1'b1);
      set_pin(p, 1'b0);
   endtask
endmodule

// ==== verification/tb_timer16_interval_ppg_capture.sv ====
`timescale 1ns/100ps
module tb_timer16_interval_ppg_capture;
   localparam int D1 = 2;
   localparam int D2 = 4;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        rd_chk = 1'b0;
   logic        rd_pend = 1'b0;
   logic [15:0] rdata;
   logic        tin0;
   logic        tin1;
   logic        tout;
   logic        irq0;
   logic        irq1;
   logic [15:0] exp_q[$];
   int          bad_count = 0;
   int          samples_checked = 0;
   int          n0 = 0;
   int          n1 = 0;
   int          exp_n[4] = '{1, 1, 0, 2};
   integer      seed = 47;

   always #5 sys_clk = ~sys_clk;

   t16_timer #(.DIV1(D1), .DIV2(D2)) dut (
      .SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .TIMER_INPUT_0(tin0), .TIMER_INPUT_1(tin1),
      .TIMER_OUTPUT_PIN(tout), .MATCH0_IRQ(irq0), .MATCH1_IRQ(irq1));

   t16_pulse_src src (.sys_clk(sys_clk), .pin0(tin0), .pin1(tin1));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (bad_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge sys_clk) rd_pend <= rd & rd_chk;
   always @(negedge sys_clk) begin
      n0 += (irq0 === 1'b1);
      n1 += (irq1 === 1'b1);
      if (rd_pend)
         chk(rdata, exp_q.pop_front());
   end

   task automatic wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [2:0] a, input logic c, output logic [15:0] v);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      rd_chk <= c;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      v = rdata;
   endtask

   task automatic expect_rd(input logic [2:0] a, input logic [15:0] e);
      logic [15:0] v;
      exp_q.push_back(e);
      rreg(a, 1'b1, v);
   endtask

   // 0 match0, 1 match1, 2 output rise, 3 output fall
   task automatic wait_ev(input int w, output time t);
      logic prev;
      prev = tout;
      t = 0;
      for (int i = 0; i < 70000; i++) begin
         @(negedge sys_clk);
         if ((w == 0 && irq0 === 1'b1) || (w == 1 && irq1 === 1'b1) ||
             (w == 2 && tout === 1'b1 && prev === 1'b0) ||
             (w == 3 && tout === 1'b0 && prev === 1'b1)) begin
            t = $time;
            return;
         end
         prev = tout;
      end
      bad_count++;
   endtask

   // pin high for 21 cycles; both captures go through the same filter delay
   task automatic width(input int pin, input logic [2:0] a1, input logic [2:0] a2,
                        input int ev2);
      time         t0;
      time         t1;
      logic [15:0] v1;
      logic [15:0] v2;
      src.set_pin(pin, 1'b1);
      t0 = $time;
      wait_ev(pin ? 0 : 1, t1);
      rreg(a1, 1'b0, v1);
      while ($time < t0 + 200) @(posedge sys_clk);
      src.set_pin(pin, 1'b0);
      if (ev2 < 2)
         wait_ev(ev2, t1);
      else
         repeat (8) @(posedge sys_clk);
      rreg(a2, 1'b0, v2);
      chk(32'(16'(v2 - v1)), 32'd21);
   endtask

   task automatic run(input logic [15:0] m);
      wreg(t16_pkg::A_MODE, 16'h0000);
      wreg(t16_pkg::A_MODE, m);
   endtask

   initial begin
      logic [15:0] n;
      logic [15:0] p;
      logic [15:0] d;
      logic [15:0] acc;
      time         ta;
      time         tb;
      time         tc;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      for (int a = 0; a < 8; a++) expect_rd(3'(a), t16_pkg::RST_WORD);
      wreg(t16_pkg::A_CNT, 16'($random(seed)));
      expect_rd(t16_pkg::A_CNT, 16'h0000);
      wreg(t16_pkg::A_PRESC, 16'h00DF);
      expect_rd(t16_pkg::A_PRESC, 16'h00D3);
      n = 16'(1 + ($random(seed) & 15));
      wreg(t16_pkg::A_CCC, 16'h0000);
      wreg(t16_pkg::A_CR0, n);
      for (int c = 0; c < 3; c++) begin
         wreg(t16_pkg::A_PRESC, 16'(c));
         run(16'h000C);
         wait_ev(0, ta);
         wait_ev(0, tb);
         chk(32'((tb - ta) / 10), (32'(n) + 1) * ((c == 0) ? 1 : (c == 1) ? D1 : D2));
      end
      expect_rd(t16_pkg::A_STAT, 16'h0000);
      wreg(t16_pkg::A_MODE, 16'h0000);
      wreg(t16_pkg::A_PRESC, 16'h0000);
      wreg(t16_pkg::A_CR0, t16_pkg::CNT_MAX);
      run(16'h000C);
      wait_ev(0, ta);
      expect_rd(t16_pkg::A_STAT, 16'h0001);
      expect_rd(t16_pkg::A_STAT, 16'h0001);
      wreg(t16_pkg::A_MODE, 16'h0000);
      wreg(t16_pkg::A_STAT, 16'h0000);
      expect_rd(t16_pkg::A_STAT, 16'h0000);
      p = 16'(12 + ($random(seed) & 15));
      d = 16'(2 + ($random(seed) & 7));
      wreg(t16_pkg::A_CR0, p);
      wreg(t16_pkg::A_CR1, d);
      wreg(t16_pkg::A_OUTC, 16'h0013);
      run(16'h000C);
      wait_ev(3, ta);
      wait_ev(2, ta);
      wait_ev(3, tb);
      wait_ev(2, tc);
      chk(32'((tb - ta) / 10), 32'(d) + 1);
      chk(32'((tc - ta) / 10), 32'(p) + 1);
      wreg(t16_pkg::A_OUTC, 16'h0003);
      wait_ev(2, ta);
      wait_ev(2, tb);
      chk(32'((tb - ta) / 10), 2 * (32'(p) + 1));
      d = d + 16'h0001;
      wreg(t16_pkg::A_CR1, d);
      repeat (2) @(posedge sys_clk);
      wreg(t16_pkg::A_OUTC, 16'h0013);
      wait_ev(2, ta);
      wait_ev(3, tb);
      wait_ev(2, tc);
      chk(32'((tc - ta) / 10), 32'(p) + 1);
      chk(32'((tb - ta) / 10 == d + 1 || (tb - ta) / 10 == p - d), 32'd1);
      wreg(t16_pkg::A_MODE, 16'h0000);
      wreg(t16_pkg::A_OUTC, 16'h0012);
      run(16'h000C);
      acc = 16'h0000;
      repeat (3 * (p + 1)) begin
         @(negedge sys_clk);
         acc = acc | 16'(tout);
      end
      chk(acc, 32'd0);
      wreg(t16_pkg::A_CCC, 16'h0005);
      for (int pin = 0; pin < 2; pin++) begin
         for (int c = 0; c < 4; c++) begin
            wreg(t16_pkg::A_MODE, 16'h0000);
            wreg(t16_pkg::A_PRESC, 16'(c << (pin ? 6 : 4)));
            run(16'h0008);
            n0 = 0;
            n1 = 0;
            src.set_pin(pin, 1'b1);
            repeat (8) @(posedge sys_clk);
            src.set_pin(pin, 1'b0);
            repeat (8) @(posedge sys_clk);
            chk(pin ? n0 : n1, exp_n[c]);
         end
      end
      wreg(t16_pkg::A_MODE, 16'h0000);
      wreg(t16_pkg::A_PRESC, 16'h00F0);
      run(16'h0008);
      n1 = 0;
      src.glitch(0);
      repeat (8) @(posedge sys_clk);
      chk(n1, 32'd0);
      width(0, t16_pkg::A_CR1, t16_pkg::A_CR1, 1);
      width(1, t16_pkg::A_CR0, t16_pkg::A_CR0, 0);
      wreg(t16_pkg::A_MODE, 16'h0000);
      wreg(t16_pkg::A_CCC, 16'h0007);
      wreg(t16_pkg::A_PRESC, 16'h0010);
      run(16'h0008);
      width(0, t16_pkg::A_CR1, t16_pkg::A_CR0, 2);
      wreg(t16_pkg::A_CCC, 16'h0004);
      run(16'h0004);
      src.set_pin(0, 1'b1);
      ta = $time;
      repeat (5) @(posedge sys_clk);
      src.set_pin(0, 1'b0);
      while ($time < ta + 290) @(posedge sys_clk);
      src.set_pin(0, 1'b1);
      wait_ev(1, tb);
      expect_rd(t16_pkg::A_CR1, 16'h001D);
      src.set_pin(0, 1'b0);
      repeat (4) @(posedge sys_clk);
      wreg(t16_pkg::A_MODE, 16'h0000);
      wreg(t16_pkg::A_PRESC, 16'h0013);
      run(16'h0008);
      // pin edges are the count clock here
      repeat (3) begin
         src.set_pin(0, 1'b1);
         repeat (3) @(posedge sys_clk);
         src.set_pin(0, 1'b0);
         repeat (3) @(posedge sys_clk);
      end
      expect_rd(t16_pkg::A_CNT, 16'h0003);
      complete_run();
   end

   initial begin
      repeat (100000) @(posedge sys_clk);
      bad_count++;
      complete_run();
   end
endmodule
